// ---- core/rtc_flag_pkg.sv ----
// constants for the clock's event flag and date alarm registers
package rtc_flag_pkg;
	localparam int INDEX_WIDTH = 7;
	localparam int DATA_WIDTH = 8;
	localparam logic [6:0] EVENT_FLAGS_INDEX = 7'h0C;
	localparam logic [6:0] VALID_DATE_INDEX = 7'h0D;
	localparam int IRQ_REQUEST_BIT = 7;
	localparam int PERIODIC_BIT = 6;
	localparam int ALARM_BIT = 5;
	localparam int UPDATE_ENDED_BIT = 4;
	localparam int VALID_RAM_TIME_BIT = 7;
	localparam int DATE_ALARM_WIDTH = 6;
	localparam int RATE_SELECT_WIDTH = 4;
	localparam int TAP_COUNT = 15;
	localparam logic [3:0] RATE_NONE = 4'h0;
	localparam logic [5:0] DATE_ALARM_DONT_CARE = 6'h00;
	localparam logic [5:0] DATE_ALARM_RESET = 6'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam int FLAG_COUNT = 3;
	localparam int FLAG_PERIODIC = 0;
	localparam int FLAG_ALARM = 1;
	localparam int FLAG_UPDATE = 2;
endpackage

// ---- core/event_flag_cell.sv ----
// one sticky event flag, set wins over a clearing read
`timescale 1ns/10ps
module event_flag_cell (
	input wire logic mclk_in,
	input wire logic well_rst_in,
	input wire logic ce_in,
	input wire logic set_in,
	input wire logic clear_in,
	output logic flag_out
);
	always_ff @(posedge mclk_in) begin
		if (well_rst_in) begin
			flag_out <= 1'b0;
		end else if (ce_in) begin
			if (set_in) begin
				flag_out <= 1'b1;
			end else if (clear_in) begin
				flag_out <= 1'b0;
			end
		end
	end
endmodule // event_flag_cell

// ---- core/periodic_tap_select.sv ----
// picks the divider tap named by the rate select field
`timescale 1ns/10ps
module periodic_tap_select
	import rtc_flag_pkg::*;
#(
	parameter int TAPS = TAP_COUNT
) (
	input wire logic [TAPS-1:0] taps_in,
	input wire logic [RATE_SELECT_WIDTH-1:0] rate_select_in,
	output logic tap_out
);
	wire logic [TAPS:0] taps_ext;
	assign taps_ext = {taps_in, 1'b0};
	// rate zero picks the constant low slot, so the flag never sets
	assign tap_out = (rate_select_in == RATE_NONE) ? 1'b0 : taps_ext[rate_select_in];
endmodule // periodic_tap_select

// ---- core/rtc_flag_and_alarm_status.sv ----
// event flag register and valid/date alarm register of the real-time clock
`timescale 1ns/10ps
module rtc_flag_and_alarm_status
	import rtc_flag_pkg::*;
#(
	parameter int TAPS = TAP_COUNT
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic resume_well_reset_n_in,
	input wire logic clock_well_reset_n_in,
	input wire logic [INDEX_WIDTH-1:0] index_in,
	input wire logic [DATA_WIDTH-1:0] wr_data_in,
	input wire logic wr_strobe_in,
	input wire logic rd_strobe_in,
	output logic [DATA_WIDTH-1:0] rd_data_out,
	input wire logic periodic_irq_enable_in,
	input wire logic alarm_irq_enable_in,
	input wire logic update_ended_irq_enable_in,
	input wire logic update_inhibit_in,
	input wire logic [RATE_SELECT_WIDTH-1:0] rate_select_in,
	input wire logic [TAPS-1:0] divider_taps_in,
	input wire logic update_done_in,
	input wire logic time_alarm_match_in,
	input wire logic date_alarm_enable_in,
	input wire logic [DATE_ALARM_WIDTH-1:0] current_day_in,
	input wire logic power_good_in,
	output logic clock_irq_out_n
);
	////////////////////////////////////////////////////////////////////////////
	// event sources
	logic tap_prev_reg;
	logic [DATE_ALARM_WIDTH-1:0] date_alarm_reg;
	logic [DATA_WIDTH-1:0] rd_data_reg;
	logic irq_n_reg;
	wire logic tap_now;
	wire logic update_ok;
	wire logic date_match;
	wire logic [FLAG_COUNT-1:0] flag_set;
	wire logic [FLAG_COUNT-1:0] flag_rst;
	wire logic [FLAG_COUNT-1:0] flag_val;
	wire logic [FLAG_COUNT-1:0] flag_en;
	wire logic rd_flags;
	wire logic wr_date;
	wire logic irq_request_flag;

	periodic_tap_select #(
		.TAPS(TAPS)
	) u_tap (
		.taps_in(divider_taps_in),
		.rate_select_in(rate_select_in),
		.tap_out(tap_now)
	);

	// an inhibited update is treated as aborted and never completes
	assign update_ok = update_done_in & ~update_inhibit_in;
	assign date_match = (date_alarm_reg == DATE_ALARM_DONT_CARE) | ~date_alarm_enable_in
		| (current_day_in == date_alarm_reg);
	assign flag_set[FLAG_PERIODIC] = tap_now & ~tap_prev_reg;
	assign flag_set[FLAG_ALARM] = update_ok & time_alarm_match_in & date_match;
	assign flag_set[FLAG_UPDATE] = update_ok;
	assign flag_rst[FLAG_PERIODIC] = ~resume_well_reset_n_in;
	assign flag_rst[FLAG_ALARM] = ~clock_well_reset_n_in;
	assign flag_rst[FLAG_UPDATE] = ~resume_well_reset_n_in;
	assign flag_en[FLAG_PERIODIC] = periodic_irq_enable_in;
	assign flag_en[FLAG_ALARM] = alarm_irq_enable_in;
	assign flag_en[FLAG_UPDATE] = update_ended_irq_enable_in;

	////////////////////////////////////////////////////////////////////////////
	// access decode
	assign rd_flags = rd_strobe_in & (index_in == EVENT_FLAGS_INDEX);
	// index 0Ch has no write path at all
	assign wr_date = wr_strobe_in & (index_in == VALID_DATE_INDEX);

	genvar gi;
	generate
		for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_flag
			event_flag_cell u_cell (
				.mclk_in(mclk_in),
				.well_rst_in(flag_rst[gi]),
				.ce_in(ce_in),
				.set_in(flag_set[gi]),
				.clear_in(rd_flags),
				.flag_out(flag_val[gi])
			);
		end
	endgenerate

	// the request is derived from the flags, so it clears with them
	assign irq_request_flag = |(flag_val & flag_en);

	////////////////////////////////////////////////////////////////////////////
	// read data
	wire logic [DATA_WIDTH-1:0] flags_word;
	wire logic [DATA_WIDTH-1:0] valid_word;
	wire logic [DATA_WIDTH-1:0] read_mux;
	assign flags_word = {irq_request_flag, flag_val[FLAG_PERIODIC], flag_val[FLAG_ALARM],
		flag_val[FLAG_UPDATE], 4'h0};
	assign valid_word = {power_good_in, 1'b0,
		date_alarm_enable_in ? date_alarm_reg : DATE_ALARM_RESET};
	assign read_mux = (index_in == EVENT_FLAGS_INDEX) ? flags_word
		: (index_in == VALID_DATE_INDEX) ? valid_word : READ_ZERO;

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			tap_prev_reg <= 1'b0;
			rd_data_reg <= READ_ZERO;
			irq_n_reg <= 1'b1;
		end else if (ce_in) begin
			tap_prev_reg <= tap_now;
			irq_n_reg <= ~irq_request_flag;
			if (rd_strobe_in) begin
				rd_data_reg <= read_mux;
			end
		end
	end

	// date alarm lives in the clock well, untouched by system reset
	always_ff @(posedge mclk_in) begin
		if (~clock_well_reset_n_in) begin
			date_alarm_reg <= DATE_ALARM_RESET;
		end else if (ce_in && wr_date) begin
			date_alarm_reg <= wr_data_in[DATE_ALARM_WIDTH-1:0];
		end
	end

	assign rd_data_out = rd_data_reg;
	assign clock_irq_out_n = irq_n_reg;
endmodule // rtc_flag_and_alarm_status

// ---- tb/rtc_flag_and_alarm_status_assertions.sv ----
// bound checker for the event flag and date alarm registers
`timescale 1ns/10ps
module rtc_flag_and_alarm_status_assertions
	import rtc_flag_pkg::*;
(
	input wire logic mclk_in, sys_rst_in, ce_in, resume_well_reset_n_in, rd_strobe_in,
	input wire logic [INDEX_WIDTH-1:0] index_in,
	input wire logic [DATA_WIDTH-1:0] rd_data_out,
	input wire logic periodic_irq_enable_in, alarm_irq_enable_in, update_ended_irq_enable_in,
	input wire logic update_done_in, update_inhibit_in, date_alarm_enable_in, power_good_in,
	input wire logic clock_irq_out_n
);
	wire logic rd_f = ce_in && rd_strobe_in && index_in == EVENT_FLAGS_INDEX;
	wire logic rd_v = ce_in && rd_strobe_in && index_in == VALID_DATE_INDEX;
	wire logic upd = ce_in && update_done_in && !update_inhibit_in && resume_well_reset_n_in;
	wire logic [2:0] ens = {periodic_irq_enable_in, alarm_irq_enable_in,
		update_ended_irq_enable_in};
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	sequence set_read; upd ##1 !rd_f ##1 rd_f; endsequence
	sequence quiet_pair; rd_f && !update_done_in ##1 !update_done_in ##1 rd_f; endsequence
	low_zero_a: assert property (rd_f |=> rd_data_out[3:0] == 4'h0)
		else $error("low bits set");
	valid_bit_a: assert property (rd_v |=> rd_data_out[7] == $past(power_good_in))
		else $error("valid bit wrong");
	reserved_bit_a: assert property (rd_v |=> !rd_data_out[6])
		else $error("bit 6 set");
	date_hidden_a: assert property (rd_v && !date_alarm_enable_in |=> rd_data_out[5:0] == 6'h00)
		else $error("date shown");
	irq_combine_a: assert property (rd_f |=> rd_data_out[7] == |(rd_data_out[6:4] & $past(ens)))
		else $error("irq bit wrong");
	irq_pin_a: assert property (rd_f |=> clock_irq_out_n == !rd_data_out[7])
		else $error("irq pin wrong");
	update_flag_a: assert property (set_read |=> rd_data_out[4])
		else $error("update flag lost");
	read_clear_a: assert property (quiet_pair |=> rd_data_out[5:4] == 2'h0)
		else $error("flags not cleared");
endmodule // rtc_flag_and_alarm_status_assertions
////////////////////////////////////////////////////////////////
bind rtc_flag_and_alarm_status rtc_flag_and_alarm_status_assertions u_checker (.*);

// ---- tb/rtc_flag_and_alarm_status_tb.sv ----
// self-checking bench for the event flag and date alarm registers
`timescale 1ns/10ps
module rtc_flag_and_alarm_status_tb import rtc_flag_pkg::*; ();
	logic mclk_in = 0, sys_rst_in = 1, ce_in = 1, resume_well_reset_n_in = 0;
	logic clock_well_reset_n_in = 0, wr_strobe_in = 0, rd_strobe_in = 0, update_done_in = 0;
	logic periodic_irq_enable_in = 0, alarm_irq_enable_in = 0, update_ended_irq_enable_in = 0;
	logic update_inhibit_in = 0, time_alarm_match_in = 0, date_alarm_enable_in = 0;
	logic power_good_in = 1, clock_irq_out_n;
	logic [6:0] index_in = 0;
	logic [7:0] wr_data_in = 0, rd_data_out;
	logic [3:0] rate_select_in = 0;
	logic [14:0] divider_taps_in = 0;
	logic [5:0] current_day_in = 0;
	int bad_count = 0, compares = 0;
	rtc_flag_and_alarm_status u_rtc_flag_and_alarm_status (.*);
	always #20 mclk_in = ~mclk_in;
	task tick; @(posedge mclk_in); #1; endtask
	task chk(input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	task acc(input logic w, input logic [6:0] idx, input logic [7:0] d);
		index_in = idx;
		wr_data_in = d;
		{wr_strobe_in, rd_strobe_in} = {w, !w};
		tick;
		{wr_strobe_in, rd_strobe_in, update_done_in} = 3'h0;
		if (!w) chk(rd_data_out, d);
		tick;
	endtask
	task rf(input logic [7:0] e); acc(0, 7'h0C, e); endtask
	task ev; update_done_in = 1; tick; update_done_in = 0; tick; endtask
	task close_out;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (3000) tick;
		bad_count++;
		close_out;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) tick;
		{sys_rst_in, resume_well_reset_n_in, clock_well_reset_n_in} = 3'h3;
		rf(8'h00);
		acc(1, 7'h0D, 8'hFF);
		date_alarm_enable_in = 1;
		acc(0, 7'h0D, 8'hBF);
		sys_rst_in = 1;
		tick;
		chk(rd_data_out, 8'h00);
		sys_rst_in = 0;
		acc(0, 7'h0D, 8'hBF);
		{date_alarm_enable_in, power_good_in} = 2'h0;
		acc(0, 7'h0D, 8'h00);
		power_good_in = 1;
		acc(1, 7'h0C, 8'hFF);
		rf(8'h00);
		{periodic_irq_enable_in, alarm_irq_enable_in, update_ended_irq_enable_in} = 3'h7;
		ev;
		chk({7'h00, clock_irq_out_n}, 8'h00);
		rf(8'h90);
		rf(8'h00);
		chk({7'h00, clock_irq_out_n}, 8'h01);
		update_inhibit_in = 1;
		ev;
		rf(8'h00);
		{update_inhibit_in, time_alarm_match_in, date_alarm_enable_in} = 3'h3;
		current_day_in = 6'h3F;
		ev;
		rf(8'hB0);
		current_day_in = 6'h01;
		ev;
		rf(8'h90);
		update_ended_irq_enable_in = 0;
		rate_select_in = 4'h2;
		divider_taps_in = 15'h0002;
		tick;
		rf(8'hC0);
		rate_select_in = 4'h0;
		divider_taps_in = 15'h7FFF;
		tick;
		rf(8'h00);
		update_done_in = 1;
		rf(8'h00);
		update_done_in = 0;
		rf(8'h10);
		ce_in = 0;
		ev;
		ce_in = 1;
		rf(8'h00);
		current_day_in = 6'h3F;
		ev;
		resume_well_reset_n_in = 0;
		tick;
		resume_well_reset_n_in = 1;
		rf(8'hA0);
		ev;
		clock_well_reset_n_in = 0;
		tick;
		clock_well_reset_n_in = 1;
		rf(8'h10);
		acc(0, 7'h0D, 8'h80);
		close_out;
	end
endmodule // rtc_flag_and_alarm_status_tb
